// ---- inc/byte_stream_if.sv ----
// Purpose: valid/ready byte stream between the loader and its buffer
// Assumes: source holds data and valid until ready
// Notes:   one transfer per cycle with valid and ready high
`timescale 1ns/1ns
interface byte_stream_if #(parameter int W = 8);
  logic         valid;  // word offered
  logic         ready;  // word taken
  logic [W-1:0] data;   // word
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ---- inc/cfg_load_pkg.sv ----
// Purpose: shared constants and state types for the scan configuration loader
// Assumes: one 125 MHz clock; all pins enter through the three-flop filter
// Notes:   pin vector positions, counts and encodings are named here only
package cfg_load_pkg;
  // clock figures
  localparam int CLK_NS          = 8;
  localparam int STARTUP_CLK_NS  = 64;                       // start-up clock period, divided down from clk_i
  localparam int STARTUP_DIV     = STARTUP_CLK_NS / CLK_NS;  // cycles per start-up tick
  localparam int DIV_W           = 4;
  // configuration memory clear before the clear-status line is let go
  localparam int CLR_CYCLES      = 16;
  localparam int CLR_W           = 8;
  // length count and readback frame
  localparam int LEN_W           = 24;
  localparam int RB_FRAME_BITS   = 64;
  localparam int RB_W            = 8;
  localparam int SHADOW_W        = 16;
  // data path
  localparam int BYTE_W          = 8;
  localparam int FIFO_DEPTH      = 8;
  localparam int BIT_CNT_W       = 3;
  // instruction register
  localparam int IR_W            = 3;
  localparam logic [IR_W-1:0] IR_LOAD   = 3'h5;  // bitstream-load opcode, value arbitrary
  localparam logic [IR_W-1:0] IR_BYPASS = 3'h7;
  // filtered pin vector positions
  localparam int P_TCK   = 0;
  localparam int P_TMS   = 1;
  localparam int P_TDI   = 2;
  localparam int P_INIT  = 3;
  localparam int P_DONE  = 4;
  localparam int P_USER_STARTUP_CLOCK  = 5;
  localparam int P_RDCLK = 6;
  localparam int P_TRIG  = 7;
  localparam int P_PROG  = 8;
  localparam int P_M0    = 9;
  localparam int P_M1    = 10;
  localparam int NPIN    = 11;
  // test access port states
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE  = 4'h1, DR_SELECT = 4'h2, DR_CAPTURE = 4'h3,
    DR_SHIFT  = 4'h4, DR_EXIT1  = 4'h5, DR_PAUSE  = 4'h6, DR_EXIT2   = 4'h7,
    DR_UPDATE = 4'h8, IR_SELECT = 4'h9, IR_CAPTURE = 4'hA, IR_SHIFT  = 4'hB,
    IR_EXIT1  = 4'hC, IR_PAUSE  = 4'hD, IR_EXIT2  = 4'hE, IR_UPDATE  = 4'hF
  } tap_state_e;
  // configuration flow
  typedef enum logic [2:0] {
    CFG_CLEAR = 3'h0, CFG_WAIT = 3'h1, CFG_LOAD = 3'h2, CFG_START = 3'h3
  } cfg_state_e;
  // start-up sequence
  typedef enum logic [2:0] {
    SU_IDLE = 3'h0, SU_DONE = 3'h1, SU_IO = 3'h2, SU_FIN = 3'h3
  } su_state_e;
endpackage

// ---- tb/scan_config_startup_sync_tb.sv ----
// Purpose: self-checking bench for scan load, start-up and readback
// Assumes: user start-up clock and tck both 64 ns
// Notes:   wired lines read high unless some party pulls low
`timescale 1ns/1ns
module scan_config_startup_sync_tb;
  logic                               clk = 1'b0;
  logic                               arst_n = 1'b0;
  logic                               prog_n = 1'b0;
  logic [1:0]                         mode = 2'h0;
  logic                               init_low = 1'b1;  // outside party holds clear-status
  logic                               done_low = 1'b1;  // outside party holds done
  logic                               wait_opt = 1'b1;
  logic                               ustart = 1'b0;
  logic [cfg_load_pkg::LEN_W-1:0]     len = 24'h00_0055;  // 80 bits plus 5 moves
  logic                               trig = 1'b0;
  logic                               rdclk = 1'b0;
  logic                               ready = 1'b0;
  logic                               init_o, init_oe, done_o, done_oe, rip, rdata, io, global_set_reset, ovr, cvalid;
  logic [1:0]                         cmode;
  logic [7:0]                         cdata;
  logic                               tck, tms, tdi, init_w, done_w;
  int                                 fail_count = 0;
  int                                 check_count = 0;
  int                                 cyc = 0;
  // wired lines with pull-ups
  assign init_w = ~((init_oe & ~init_o) | init_low);
  assign done_w = ~((done_oe & ~done_o) | done_low);
  always #4 clk = ~clk;
  scan_master tap (.clk_i(clk), .init_i(init_w), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  scan_config_startup_sync dut (.clk_i(clk), .arst_n_i(arst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .prog_n_i(prog_n), .mode_i(mode), .init_i(init_w), .init_o(init_o), .init_oe_o(init_oe),
    .done_i(done_w), .done_o(done_o), .done_oe_o(done_oe), .user_clk_wait_on_complete_i(wait_opt),
    .user_clk_no_wait_i(1'b0), .user_startup_clock_i(ustart), .length_count_i(len),
    .readback_trigger_i(trig), .readback_clk_i(rdclk), .readback_in_progress_o(rip),
    .readback_data_o(rdata), .config_mode_o(cmode), .user_io_active_o(io), .global_set_reset_o(global_set_reset),
    .overrun_o(ovr), .cfg_valid_o(cvalid), .cfg_data_o(cdata), .cfg_ready_i(ready));
  // user start-up clock and run ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ustart <= cyc[2];
    if (cyc == 6000) begin
      fail_count++;
      complete_run();
    end
  end
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  // counts and verdict
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // held clear-status, load opcode, mode capture on release
  task automatic t_clear();
    prog_n <= 1'b1;
    mode <= 2'h2;
    trig <= 1'b1;  // armed before finish
    repeat (40) @(posedge clk);
    check(cmode, 2'h0, "mode taken while held");
    tap.send_load();
    init_low <= 1'b0;
    repeat (8) @(posedge clk);
    check(cmode, 2'h2, "mode capture");
    $display("test clear done");
  endtask
  // ten bytes into a stalled fifo: ninth waits, tenth overwrites it, then drain nine
  task automatic t_load();
    tap.send_data(10);
    repeat (4) @(posedge clk);
    check(ovr, 1'b1, "lost byte not flagged");
    for (int k = 0; k < 9; k++) begin
      check(cdata, (k < 8) ? 8'h10 + 8'(k) : 8'h19, "byte value");
      ready <= 1'b1;
      @(posedge clk);
      ready <= 1'b0;
      @(posedge clk);
    end
    check(cvalid, 1'b0, "fifo not empty");
    $display("test load done");
  endtask
  // start-up stalled by done, then ordered release
  task automatic t_startup();
    int n;
    repeat (40) @(posedge clk);
    check(done_oe, 1'b0, "done not released");
    check(io, 1'b0, "io active while done held");
    done_low <= 1'b0;
    n = 0;
    while (io !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(global_set_reset, 1'b1, "set/reset released early");
    check(rip, 1'b0, "readback before finish");
    n = 0;
    while (global_set_reset !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(8'(n), 8'h08, "io to set/reset gap");
    repeat (2) @(posedge clk);
    check(rip, 1'b1, "finish did not start readback");
    $display("test startup done");
  endtask
  // full readback frame of the last sixteen bits
  task automatic t_readback();
    logic [15:0] exp;
    exp = 16'h1918;
    for (int i = 0; i < 64; i++) begin
      rdclk <= 1'b1;
      repeat (6) @(posedge clk);
      check(rdata, exp[i % 16], "readback bit");
      rdclk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    check(rip, 1'b0, "readback still flagged");
    $display("test readback done");
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    t_clear();
    t_load();
    t_startup();
    t_readback();
    complete_run();
  end
endmodule

// ---- tb/scan_master.sv ----
// Purpose: scan-port master model that loads a bitstream
// Assumes: tasks are entered just after a clk_i rising edge
// Notes:   tck stands low between frames
`timescale 1ns/1ns
module scan_master (
  // clock and clear-status wire
  input  wire logic clk_i,
  input  wire logic init_i,
  // scan pins
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  // idle levels at time zero
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one 64 ns tck period, tms and tdi set up in the low half
  task automatic tick(input logic m, input logic d);
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask
  // idle, ir shift, opcode lsb first, update, idle
  task automatic send_load();
    logic [9:0] m;
    logic [9:0] d;
    m = 10'h186;
    d = {2'h0, cfg_load_pkg::IR_LOAD, 5'h00};
    for (int i = 0; i < 10; i++) tick(m[i], d[i]);
  endtask
  // dr shift once clear-status is high, bytes 8'h10 upward, lsb first
  task automatic send_data(input int nbytes);
    logic [7:0] b;
    wait (init_i === 1'b1);
    @(posedge clk_i);
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int k = 0; k < nbytes; k++) begin
      b = 8'h10 + 8'(k);
      for (int j = 0; j < 8; j++) tick(k == nbytes - 1 && j == 7, b[j]);
    end
    tick(1'b1, 1'b0);
    tick(1'b0, ~tdi_o);  // released line shows the inverse
  endtask
endmodule

// ---- verilog/byte_fifo.sv ----
// Purpose: small synchronous fifo for configuration bytes
// Assumes: single clock, write and read may happen together
// Notes:   ready on the write side is low exactly when full
`timescale 1ns/1ns
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // streams
  byte_stream_if.sink   wr,
  byte_stream_if.source rd
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];         // storage
  logic [AW:0]  wp_r, wp_nxt;      // write pointer with wrap bit
  logic [AW:0]  rp_r, rp_nxt;      // read pointer with wrap bit
  logic         full, empty;

  // honest full and empty from the pointers
  assign full     = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty    = (wp_r == rp_r);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_r[rp_r[AW-1:0]];

  // pointer advance
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (wr.valid && !full) begin
      wp_nxt = wp_r + 1'b1;
    end
    if (rd.ready && !empty) begin
      rp_nxt = rp_r + 1'b1;
    end
  end

  // pointer registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (wr.valid && !full) begin
      mem_r[wp_r[AW-1:0]] <= wr.data;
    end
  end
endmodule

// ---- verilog/scan_config_startup_sync.sv ----
// Purpose: scan-port bitstream load, start-up sequencing and first readback
// Assumes: all pins asynchronous to clk_i; tck and readback clock far below clk_i
// Notes:   open-drain pins come as input, output and output enable
`timescale 1ns/1ns
module scan_config_startup_sync (
  // clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               arst_n_i,
  // test access port pins
  input  wire logic                               tck_i,
  input  wire logic                               tms_i,
  input  wire logic                               tdi_i,
  // configuration control pins
  input  wire logic                               prog_n_i,
  input  wire logic [1:0]                         mode_i,
  input  wire logic                               init_i,
  output logic                                    init_o,
  output logic                                    init_oe_o,
  input  wire logic                               done_i,
  output logic                                    done_o,
  output logic                                    done_oe_o,
  // start-up options and user clock
  input  wire logic                               user_clk_wait_on_complete_i,
  input  wire logic                               user_clk_no_wait_i,
  input  wire logic                               user_startup_clock_i,
  input  wire logic [cfg_load_pkg::LEN_W-1:0]     length_count_i,
  // readback
  input  wire logic                               readback_trigger_i,
  input  wire logic                               readback_clk_i,
  output logic                                    readback_in_progress_o,
  output logic                                    readback_data_o,
  // status
  output logic [1:0]                              config_mode_o,
  output logic                                    user_io_active_o,
  output logic                                    global_set_reset_o,
  output logic                                    overrun_o,
  // configuration byte stream
  output logic                                    cfg_valid_o,
  output logic [cfg_load_pkg::BYTE_W-1:0]         cfg_data_o,
  input  wire logic                               cfg_ready_i
);
  // tap next state
  function automatic cfg_load_pkg::tap_state_e tap_next(input cfg_load_pkg::tap_state_e s, input logic tms);
    case (s)
      cfg_load_pkg::TAP_RESET:  tap_next = tms ? cfg_load_pkg::TAP_RESET : cfg_load_pkg::TAP_IDLE;
      cfg_load_pkg::TAP_IDLE:   tap_next = tms ? cfg_load_pkg::DR_SELECT : cfg_load_pkg::TAP_IDLE;
      cfg_load_pkg::DR_SELECT:  tap_next = tms ? cfg_load_pkg::IR_SELECT : cfg_load_pkg::DR_CAPTURE;
      cfg_load_pkg::DR_CAPTURE: tap_next = tms ? cfg_load_pkg::DR_EXIT1 : cfg_load_pkg::DR_SHIFT;
      cfg_load_pkg::DR_SHIFT:   tap_next = tms ? cfg_load_pkg::DR_EXIT1 : cfg_load_pkg::DR_SHIFT;
      cfg_load_pkg::DR_EXIT1:   tap_next = tms ? cfg_load_pkg::DR_UPDATE : cfg_load_pkg::DR_PAUSE;
      cfg_load_pkg::DR_PAUSE:   tap_next = tms ? cfg_load_pkg::DR_EXIT2 : cfg_load_pkg::DR_PAUSE;
      cfg_load_pkg::DR_EXIT2:   tap_next = tms ? cfg_load_pkg::DR_UPDATE : cfg_load_pkg::DR_SHIFT;
      cfg_load_pkg::DR_UPDATE:  tap_next = tms ? cfg_load_pkg::DR_SELECT : cfg_load_pkg::TAP_IDLE;
      cfg_load_pkg::IR_SELECT:  tap_next = tms ? cfg_load_pkg::TAP_RESET : cfg_load_pkg::IR_CAPTURE;
      cfg_load_pkg::IR_CAPTURE: tap_next = tms ? cfg_load_pkg::IR_EXIT1 : cfg_load_pkg::IR_SHIFT;
      cfg_load_pkg::IR_SHIFT:   tap_next = tms ? cfg_load_pkg::IR_EXIT1 : cfg_load_pkg::IR_SHIFT;
      cfg_load_pkg::IR_EXIT1:   tap_next = tms ? cfg_load_pkg::IR_UPDATE : cfg_load_pkg::IR_PAUSE;
      cfg_load_pkg::IR_PAUSE:   tap_next = tms ? cfg_load_pkg::IR_EXIT2 : cfg_load_pkg::IR_PAUSE;
      cfg_load_pkg::IR_EXIT2:   tap_next = tms ? cfg_load_pkg::IR_UPDATE : cfg_load_pkg::IR_SHIFT;
      default:                  tap_next = tms ? cfg_load_pkg::DR_SELECT : cfg_load_pkg::TAP_IDLE;
    endcase
  endfunction

  // pin filter: three flops, change accepted when second and third agree
  logic [cfg_load_pkg::NPIN-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt, rise;
  logic [cfg_load_pkg::NPIN-1:0] pins;
  assign pins = {mode_i[1], mode_i[0], prog_n_i, readback_trigger_i, readback_clk_i,
                 user_startup_clock_i, done_i, init_i, tdi_i, tms_i, tck_i};

  // filter next value and edge finder
  always_comb begin
    filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
    rise     = filt_nxt & ~filt_r;
  end

  // filter registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r   <= '0;
      s2_r   <= '0;
      s3_r   <= '0;
      filt_r <= '0;
    end else begin
      s1_r   <= pins;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // state of all groups
  cfg_load_pkg::tap_state_e      tap_r, tap_nxt;
  cfg_load_pkg::cfg_state_e      cfg_r, cfg_nxt;
  cfg_load_pkg::su_state_e       su_r, su_nxt;
  logic [cfg_load_pkg::IR_W-1:0]     ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;      // instruction shift and hold
  logic [cfg_load_pkg::CLR_W-1:0]    clr_r, clr_nxt;                         // memory clear timer
  logic [cfg_load_pkg::LEN_W-1:0]    tck_cnt_r, tck_cnt_nxt;                 // length count progress
  logic [1:0]                        mode_r, mode_nxt;                       // captured mode
  logic [cfg_load_pkg::BYTE_W-1:0]   byte_r, byte_nxt;                       // assembling byte
  logic [cfg_load_pkg::BIT_CNT_W-1:0] bit_r, bit_nxt;                        // bits in byte
  logic                              pend_r, pend_nxt, ovr_r, ovr_nxt, ovr_set;  // byte waiting, overrun, loss event
  logic [cfg_load_pkg::SHADOW_W-1:0] shadow_r, shadow_nxt;                   // last bits loaded
  logic [cfg_load_pkg::DIV_W-1:0]    div_r, div_nxt;                         // start-up clock divider
  logic                              done_rel_r, done_rel_nxt, io_r, io_nxt, gsr_r, gsr_nxt;
  logic                              rip_r, rip_nxt, rbd_r, rbd_nxt;         // readback flag and data
  logic [cfg_load_pkg::RB_W-1:0]     rb_cnt_r, rb_cnt_nxt;                   // readback bit count
  logic [cfg_load_pkg::SHADOW_W-1:0] rb_sh_r, rb_sh_nxt;                     // readback shifter
  logic                              tck_rise, shifting, su_tick, user_clk_sel, push_ready;

  assign tck_rise     = rise[cfg_load_pkg::P_TCK];
  assign shifting     = (tap_r == cfg_load_pkg::DR_SHIFT) && (ir_r == cfg_load_pkg::IR_LOAD);
  assign user_clk_sel = user_clk_wait_on_complete_i | user_clk_no_wait_i;
  assign su_tick      = user_clk_sel ? rise[cfg_load_pkg::P_USER_STARTUP_CLOCK] : (div_r == '0);

  // tap controller and instruction register, stepped on tck rise
  always_comb begin
    tap_nxt   = tap_r;
    ir_sh_nxt = ir_sh_r;
    ir_nxt    = ir_r;
    if (tck_rise) begin
      tap_nxt = tap_next(tap_r, filt_r[cfg_load_pkg::P_TMS]);
      if (tap_r == cfg_load_pkg::IR_SHIFT) begin
        ir_sh_nxt = {filt_r[cfg_load_pkg::P_TDI], ir_sh_r[cfg_load_pkg::IR_W-1:1]};
      end
      if (tap_r == cfg_load_pkg::IR_UPDATE) begin
        ir_nxt = ir_sh_r;
      end
      if (tap_r == cfg_load_pkg::TAP_RESET) begin
        ir_nxt = cfg_load_pkg::IR_BYPASS;
      end
    end
  end

  // configuration flow: clear, wait on clear-status, load, start-up
  always_comb begin
    cfg_nxt     = cfg_r;
    clr_nxt     = clr_r;
    tck_cnt_nxt = tck_cnt_r;
    mode_nxt    = mode_r;
    byte_nxt    = byte_r;
    bit_nxt     = bit_r;
    shadow_nxt  = shadow_r;
    pend_nxt    = pend_r && !push_ready;
    ovr_nxt     = ovr_r;
    ovr_set     = 1'b0;
    case (cfg_r)
      cfg_load_pkg::CFG_CLEAR: begin
        clr_nxt = clr_r + 1'b1;
        if (clr_r == cfg_load_pkg::CLR_W'(cfg_load_pkg::CLR_CYCLES - 1)) begin
          cfg_nxt = cfg_load_pkg::CFG_WAIT;
        end
      end
      cfg_load_pkg::CFG_WAIT: begin
        if (filt_r[cfg_load_pkg::P_INIT]) begin
          mode_nxt    = {filt_r[cfg_load_pkg::P_M1], filt_r[cfg_load_pkg::P_M0]};
          tck_cnt_nxt = '0;
          cfg_nxt     = cfg_load_pkg::CFG_LOAD;
        end
      end
      cfg_load_pkg::CFG_LOAD: begin
        if (tck_rise) begin
          tck_cnt_nxt = tck_cnt_r + 1'b1;
          if (shifting) begin
            byte_nxt   = {filt_r[cfg_load_pkg::P_TDI], byte_r[cfg_load_pkg::BYTE_W-1:1]};
            shadow_nxt = {filt_r[cfg_load_pkg::P_TDI], shadow_r[cfg_load_pkg::SHADOW_W-1:1]};
            bit_nxt    = bit_r + 1'b1;
            if (bit_r == '1) begin
              pend_nxt = 1'b1;
              ovr_set  = pend_r && !push_ready;                           // byte lost when full
              ovr_nxt  = ovr_r | ovr_set;
            end
          end
        end
        if (tck_cnt_r == length_count_i && length_count_i != '0) begin
          cfg_nxt = cfg_load_pkg::CFG_START;
        end
      end
      default: ;
    endcase
    if (!filt_r[cfg_load_pkg::P_PROG]) begin                             // reprogram restarts clear
      cfg_nxt = cfg_load_pkg::CFG_CLEAR;
      clr_nxt = '0;
      bit_nxt = '0;
      ovr_nxt = ovr_set;                                                  // a loss in the same cycle wins
    end
  end

  // start-up sequencer and its divider
  always_comb begin
    su_nxt       = su_r;
    done_rel_nxt = done_rel_r;
    io_nxt       = io_r;
    gsr_nxt      = gsr_r;
    div_nxt      = (div_r == '0) ? cfg_load_pkg::DIV_W'(cfg_load_pkg::STARTUP_DIV - 1) : div_r - 1'b1;
    if (cfg_r != cfg_load_pkg::CFG_START) begin
      su_nxt       = cfg_load_pkg::SU_IDLE;
      done_rel_nxt = 1'b0;
      io_nxt       = 1'b0;
      gsr_nxt      = 1'b1;
    end else if (su_tick) begin
      case (su_r)
        cfg_load_pkg::SU_IDLE: begin
          done_rel_nxt = 1'b1;
          su_nxt       = cfg_load_pkg::SU_DONE;
        end
        cfg_load_pkg::SU_DONE: begin
          if (!user_clk_wait_on_complete_i || filt_r[cfg_load_pkg::P_DONE]) begin
            io_nxt = 1'b1;
            su_nxt = cfg_load_pkg::SU_IO;
          end
        end
        cfg_load_pkg::SU_IO: begin
          gsr_nxt = 1'b0;
          su_nxt  = cfg_load_pkg::SU_FIN;
        end
        default: ;
      endcase
    end
  end

  // readback: first one on finish with trigger high, later ones on trigger rise
  always_comb begin
    rip_nxt    = rip_r;
    rbd_nxt    = rbd_r;
    rb_cnt_nxt = rb_cnt_r;
    rb_sh_nxt  = rb_sh_r;
    if (!rip_r) begin
      if ((su_nxt == cfg_load_pkg::SU_FIN && su_r != cfg_load_pkg::SU_FIN && filt_r[cfg_load_pkg::P_TRIG])
          || (su_r == cfg_load_pkg::SU_FIN && rise[cfg_load_pkg::P_TRIG])) begin
        rip_nxt    = 1'b1;
        rb_cnt_nxt = '0;
        rb_sh_nxt  = shadow_r;
      end
    end else if (rise[cfg_load_pkg::P_RDCLK]) begin
      rbd_nxt    = rb_sh_r[0];
      rb_sh_nxt  = {rb_sh_r[0], rb_sh_r[cfg_load_pkg::SHADOW_W-1:1]};
      rb_cnt_nxt = rb_cnt_r + 1'b1;
      if (rb_cnt_r == cfg_load_pkg::RB_W'(cfg_load_pkg::RB_FRAME_BITS - 1)) begin
        rip_nxt = 1'b0;
      end
    end
    if (cfg_r != cfg_load_pkg::CFG_START) begin
      rip_nxt = 1'b0;
    end
  end

  // registers of all groups
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tap_r <= cfg_load_pkg::TAP_RESET;  ir_sh_r <= '0;  ir_r <= cfg_load_pkg::IR_BYPASS;
      cfg_r <= cfg_load_pkg::CFG_CLEAR;  clr_r <= '0;    tck_cnt_r <= '0;  mode_r <= '0;
      byte_r <= '0;  bit_r <= '0;  pend_r <= 1'b0;  ovr_r <= 1'b0;  shadow_r <= '0;
      su_r <= cfg_load_pkg::SU_IDLE;  div_r <= '0;  done_rel_r <= 1'b0;  io_r <= 1'b0;  gsr_r <= 1'b1;
      rip_r <= 1'b0;  rbd_r <= 1'b0;  rb_cnt_r <= '0;  rb_sh_r <= '0;
    end else begin
      tap_r <= tap_nxt;  ir_sh_r <= ir_sh_nxt;  ir_r <= ir_nxt;
      cfg_r <= cfg_nxt;  clr_r <= clr_nxt;  tck_cnt_r <= tck_cnt_nxt;  mode_r <= mode_nxt;
      byte_r <= byte_nxt;  bit_r <= bit_nxt;  pend_r <= pend_nxt;  ovr_r <= ovr_nxt;  shadow_r <= shadow_nxt;
      su_r <= su_nxt;  div_r <= div_nxt;  done_rel_r <= done_rel_nxt;  io_r <= io_nxt;  gsr_r <= gsr_nxt;
      rip_r <= rip_nxt;  rbd_r <= rbd_nxt;  rb_cnt_r <= rb_cnt_nxt;  rb_sh_r <= rb_sh_nxt;
    end
  end

  // byte buffer between the scan port and the frame writer
  byte_stream_if #(.W(cfg_load_pkg::BYTE_W)) push_if ();
  byte_stream_if #(.W(cfg_load_pkg::BYTE_W)) pop_if ();
  assign push_if.valid = pend_r;
  assign push_if.data  = byte_r;
  assign push_ready    = push_if.ready;
  assign pop_if.ready  = cfg_ready_i;
  byte_fifo #(.W(cfg_load_pkg::BYTE_W), .D(cfg_load_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .wr       (push_if.sink),
    .rd       (pop_if.source)
  );

  // outputs
  assign cfg_valid_o            = pop_if.valid;
  assign cfg_data_o             = pop_if.data;
  assign init_o                 = 1'b0;
  assign init_oe_o              = (cfg_r == cfg_load_pkg::CFG_CLEAR);
  assign done_o                 = 1'b0;
  assign done_oe_o              = !done_rel_r;
  assign config_mode_o          = mode_r;
  assign user_io_active_o       = io_r;
  assign global_set_reset_o     = gsr_r;
  assign overrun_o              = ovr_r;
  assign readback_in_progress_o = rip_r;
  assign readback_data_o        = rbd_r;

  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_done_then_io;
    $rose(io_r) ##0 done_rel_r;
  endsequence
  property p_wait_init; cfg_r == cfg_load_pkg::CFG_WAIT && !filt_r[cfg_load_pkg::P_INIT] && filt_r[cfg_load_pkg::P_PROG]
    |=> cfg_r == cfg_load_pkg::CFG_WAIT; endproperty
  a_wait_init: assert property (p_wait_init) else $error("left wait while clear-status low");
  property p_mode_cap; cfg_r == cfg_load_pkg::CFG_WAIT && filt_r[cfg_load_pkg::P_INIT] && filt_r[cfg_load_pkg::P_PROG]
    |=> cfg_r == cfg_load_pkg::CFG_LOAD && mode_r == $past({filt_r[cfg_load_pkg::P_M1], filt_r[cfg_load_pkg::P_M0]});
  endproperty
  a_mode_cap: assert property (p_mode_cap) else $error("mode not captured");
  property p_tck_count; cfg_r == cfg_load_pkg::CFG_LOAD && cfg_nxt == cfg_load_pkg::CFG_LOAD && tck_rise
    |=> tck_cnt_r == $past(tck_cnt_r) + 1'b1; endproperty
  a_tck_count: assert property (p_tck_count) else $error("tck cycle not counted");
  property p_done_stall; su_r == cfg_load_pkg::SU_DONE && user_clk_wait_on_complete_i && !filt_r[cfg_load_pkg::P_DONE]
    && cfg_r == cfg_load_pkg::CFG_START |=> !io_r; endproperty
  a_done_stall: assert property (p_done_stall) else $error("start-up passed held done");
  property p_io_order; $rose(io_r) |-> s_done_then_io and $past(done_rel_r, 2); endproperty
  a_io_order: assert property (p_io_order) else $error("io active before done release");
  property p_gsr_order; $fell(gsr_r) |-> $past(io_r); endproperty
  a_gsr_order: assert property (p_gsr_order) else $error("set/reset released before io");
  property p_fin_trig; su_r != cfg_load_pkg::SU_FIN ##1 su_r == cfg_load_pkg::SU_FIN && $past(filt_r[cfg_load_pkg::P_TRIG])
    && cfg_r == cfg_load_pkg::CFG_START |-> rip_r; endproperty
  a_fin_trig: assert property (p_fin_trig) else $error("finish did not start readback");
  property p_rb_end; rip_r && rise[cfg_load_pkg::P_RDCLK] && rb_cnt_r == cfg_load_pkg::RB_W'(cfg_load_pkg::RB_FRAME_BITS - 1)
    |=> !rip_r; endproperty
  a_rb_end: assert property (p_rb_end) else $error("readback did not end after frame");
endmodule
